// File: dv/color_sensor_measurement_sequence_tb.sv
`default_nettype none
// ==========================================================
// Self-checking bench for the measurement core
module color_sensor_measurement_sequence_tb;
  import csm_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic       i_clk_sys = 1'h0;                          // System clock
  logic       i_srst    = 1'h1;                          // Synchronous reset
  logic [7:0] lvl [4]   = '{8'h01, 8'h02, 8'h03, 8'h04}; // Levels r g b ir
  wire logic  scl;                                       // Host bus clock
  wire logic  sda_drv;                                   // Host data drive
  wire logic  sda_out;                                   // Device data value
  wire logic  sda_oe;                                    // Device pulls low
  wire logic  meas_active;                               // Measuring
  wire logic  result_update;                             // Results published
  wire logic  sda_wire = sda_drv & ~(sda_oe & ~sda_out); // Open drain
  int         n_mismatch = 0;                            // Mismatches
  int         checked    = 0;                            // Comparisons
  always #5 i_clk_sys = ~i_clk_sys;
  // Short unit steps keep a full cycle to a few thousand clocks
  csm_top #(.P_TINT00_CYC(2), .P_TINT01_CYC(4), .P_TINT10_CYC(6), .P_TINT11_CYC(8)) i_csm_top (
    .i_clk_sys(i_clk_sys), .i_srst(i_srst), .i_scl(scl), .i_sda(sda_wire),
    .o_sda_out(sda_out), .o_sda_oe(sda_oe), .i_lvl_red(lvl[0]), .i_lvl_green(lvl[1]),
    .i_lvl_blue(lvl[2]), .i_lvl_ir(lvl[3]), .o_meas_active(meas_active),
    .o_result_update(result_update));
  csm_host_model i_csm_host_model (
    .i_clk_sys(i_clk_sys), .i_sda_wire(sda_wire), .o_scl(scl), .o_sda_drv(sda_drv));
  // ==========================================================
  // Shared helpers
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Pointer then data; without stop a repeated start follows
  task automatic wr(input logic [7:0] q[$], input logic stp);
    logic ack;
    i_csm_host_model.start();
    i_csm_host_model.wbyte({CSM_SLAVE_ADDR, 1'h0}, ack);
    chk("addr ack", 16'(ack), 16'h0001);
    foreach (q[i]) begin
      i_csm_host_model.wbyte(q[i], ack);
      chk("data ack", 16'(ack), 16'h0001);
    end
    if (stp) begin
      i_csm_host_model.stop();
    end
  endtask
  // Pointer write, repeated start, n bytes with nack on the last
  task automatic rd(input logic [7:0] ptr, input int n, output logic [7:0] q[$]);
    logic       ack;
    logic [7:0] b;
    q = {};
    wr({ptr}, 1'h0);
    i_csm_host_model.start();
    i_csm_host_model.wbyte({CSM_SLAVE_ADDR, CSM_DIR_READ}, ack);
    chk("read addr ack", 16'(ack), 16'h0001);
    for (int i = 0; i < n; i++) begin
      i_csm_host_model.rbyte(i == n - 1, b);
      q.push_back(b);
    end
    i_csm_host_model.stop();
  endtask
  // Bounded wait for the next publish pulse
  task automatic wait_upd(output int n);
    n = 0;
    do begin
      @(posedge i_clk_sys);
      #1;
      n++;
    end while (result_update !== 1'h1 && n < 8000);
    chk("update in time", 16'(n < 8000), 16'h0001);
  endtask
  // All eight result bytes against the given steps of each level
  task automatic chk_results(input int steps);
    logic [7:0]  q[$];
    logic [15:0] e;
    rd(CSM_REG_RES0, 8, q);
    for (int c = 0; c < CSM_NUM_CH; c++) begin
      e = 16'(steps * lvl[c]);
      chk("result high", {8'h00, q[2*c]}, {8'h00, e[15:8]});
      chk("result low", {8'h00, q[2*c+1]}, {8'h00, e[7:0]});
    end
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_reset_values();
    logic [7:0] q[$];
    chk("idle after reset", 16'(meas_active), 16'h0000);
    rd(CSM_REG_CTRL, 3, q);
    chk("ctrl reset", {8'h00, q[0]}, 16'h00C0);
    chk("manual reset", {q[1], q[2]}, 16'h0000);
  endtask
  // Another address is ignored, data byte too
  task automatic t_foreign_addr();
    logic ack;
    i_csm_host_model.start();
    i_csm_host_model.wbyte({CSM_SLAVE_ADDR ^ 7'h01, 1'h0}, ack);
    chk("foreign ack", 16'(ack), 16'h0000);
    i_csm_host_model.wbyte(8'h00, ack);
    chk("ignored byte", 16'(ack), 16'h0000);
    i_csm_host_model.stop();
  endtask
  // Manual setup burst, then release through a repeated start
  task automatic t_configure();
    logic [7:0] q[$];
    wr({8'h00, 8'h85, 8'h01, 8'h65}, 1'h0);
    chk("held in reset", 16'(meas_active), 16'h0000);
    wr({8'h00, 8'h05}, 1'h1);
    chk("measuring", 16'(meas_active), 16'h0001);
    rd(CSM_REG_CTRL, 3, q);
    chk("ctrl", {8'h00, q[0]}, 16'h0005);
    chk("manual count", {q[1], q[2]}, 16'h0165);
  endtask
  task automatic t_results();
    int n;
    wait_upd(n);
    chk_results(357);
  endtask
  // New levels, one whole cycle, cycle length within 5712 to 5716 clocks
  task automatic t_repeat();
    int n;
    wait_upd(n);
    lvl = '{8'h05, 8'h06, 8'h07, 8'h08};
    wait_upd(n);
    chk("cycle length", 16'(n >= 5712 && n <= 5716), 16'h0001);
    chk_results(357);
  endtask
  // Fixed timing, longest step code (8 clocks here): one step per channel
  task automatic t_fixed_mode();
    int n;
    wr({8'h00, 8'h83}, 1'h0);
    wr({8'h00, 8'h03}, 1'h1);
    chk("fixed measuring", 16'(meas_active), 16'h0001);
    wait_upd(n);
    wait_upd(n);
    chk("fixed cycle", 16'(n), 16'(CSM_NUM_CH * 8));
    chk_results(1);
  endtask
  // ==========================================================
  // Verdict, main sequence and watchdog
  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge i_clk_sys);
    #1;
    i_srst = 1'h0;
    repeat (3) @(posedge i_clk_sys);
    #1;
    t_reset_values();
    t_foreign_addr();
    t_configure();
    t_results();
    t_repeat();
    t_fixed_mode();
    print_verdict();
  end
  // Twice the expected run length
  initial begin
    repeat (60000) @(posedge i_clk_sys);
    n_mismatch++;
    print_verdict();
  end
endmodule
bind csm_top csm_properties #(.P_TINT00_CYC(P_TINT00_CYC)) i_csm_properties (
  .i_clk_sys(i_clk_sys), .i_srst(i_srst), .i_scl(i_scl), .i_sda(i_sda),
  .o_sda_out(o_sda_out), .o_sda_oe(o_sda_oe), .o_meas_active(o_meas_active),
  .o_result_update(o_result_update));
`default_nettype wire

// File: dv/csm_host_model.sv
`default_nettype none
// ==========================================================
// Bus host model; released lines read high through the pull-up
module csm_host_model (
  // Clock
  input  wire logic i_clk_sys,
  // Data wire level
  input  wire logic i_sda_wire,
  // Host pins, 1 means released
  output var  logic o_scl,
  output var  logic o_sda_drv
);
  // Idle bus at time zero
  initial begin
    o_scl = 1'h1;
    o_sda_drv = 1'h1;
  end
  // Clock first, data one cycle later so no false start is seen
  task automatic drv(input logic c, input logic d, output logic s);
    o_scl = c;
    @(posedge i_clk_sys) #1;
    o_sda_drv = d;
    repeat (10) @(posedge i_clk_sys);
    #1;
    s = i_sda_wire;
  endtask
  // Start or repeated start
  task automatic start();
    logic s;
    drv(1'h0, 1'h1, s);
    drv(1'h1, 1'h1, s);
    drv(1'h1, 1'h0, s);
  endtask
  // Stop frees the bus
  task automatic stop();
    logic s;
    drv(1'h0, 1'h0, s);
    drv(1'h1, 1'h0, s);
    drv(1'h1, 1'h1, s);
  endtask
  // Host byte, MSB first; returns the acknowledge seen
  task automatic wbyte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      drv(1'h0, b[i], s);
      drv(1'h1, b[i], s);
    end
    drv(1'h0, 1'h1, s);
    drv(1'h1, 1'h1, s);
    ack = ~s;
  endtask
  // Device byte; host acknowledges unless told otherwise
  task automatic rbyte(input logic nack, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      drv(1'h0, 1'h1, s);
      drv(1'h1, 1'h1, s);
      b[i] = s;
    end
    drv(1'h0, nack, s);
    drv(1'h1, nack, s);
  endtask
endmodule
`default_nettype wire

// File: dv/csm_properties.sv
`default_nettype none
// ==========================================================
// Port-level checks for the measurement core
module csm_properties #(
  parameter int P_TINT00_CYC = 10  // Shortest unit step in cycles
) (
  // Clock and reset
  input  wire logic i_clk_sys,
  input  wire logic i_srst,
  // Serial bus pins
  input  wire logic i_scl,
  input  wire logic i_sda,
  input  wire logic o_sda_out,
  input  wire logic o_sda_oe,
  // Status
  input  wire logic o_meas_active,
  input  wire logic o_result_update
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_srst);
  // ==========================================================
  // Cycles since the measurement cycle last restarted
  logic [31:0] cyc_cnt;  // Cleared on publish or when idle
  always_ff @(posedge i_clk_sys) begin
    if (i_srst || !o_meas_active || o_result_update) begin
      cyc_cnt <= 32'h0000_0000;
    end else begin
      cyc_cnt <= cyc_cnt + 32'h0000_0001;
    end
  end
  // ==========================================================
  // Assertions
  out_zero_a: assert property (o_sda_out == 1'h0)
    else $error("data pin output value not zero");
  reset_quiet_a: assert property ($fell(i_srst) |-> !o_sda_oe && !o_meas_active)
    else $error("outputs busy right after reset");
  oe_scl_low_a: assert property ($changed(o_sda_oe) |-> !i_scl)
    else $error("data drive changed while bus clock high");
  oe_hold_a: assert property ($rose(o_sda_oe) |-> o_sda_oe [*8])
    else $error("data drive shorter than a bus bit");
  start_free_a: assert property ($fell(i_sda) && i_scl |-> !o_sda_oe)
    else $error("device drives data during a start");
  upd_pulse_a: assert property (o_result_update |=> !o_result_update)
    else $error("publish pulse longer than one cycle");
  upd_active_a: assert property (o_result_update |-> o_meas_active)
    else $error("results published while not measuring");
  cycle_min_a: assert property (o_result_update |->
      cyc_cnt + 32'h0000_0002 >= 32'(4 * P_TINT00_CYC))
    else $error("measurement cycle too short");
  // ==========================================================
  // Main scenarios reached
  upd_seen_c: cover property (o_result_update);
  ack_seen_c: cover property ($rose(o_sda_oe));
  run_seen_c: cover property ($rose(o_meas_active));
endmodule
`default_nettype wire

// File: logic/csm_pkg.sv
// Operation
// (R1) Start plus address 0x2A; others ignored
// (R2) Host points at control byte with 0x00
// (R3) 0x85 holds reset, wakes, selects manual
// (R4) Manual count follows, high byte first
// (R5) Writing 0x05 releases reset, starts measuring
// (R6) Channel time is count times step unit
// (R7) Host waits beyond total integration time
// (R8) Cycles repeat; results update per cycle
// (R9) Pointer 0x03 selects first result byte
// (R10) Read address acknowledged, device drives data
// (R11) First read byte is red high
// (R12) Device acks host bytes; host acks reads
// (R13) Then green, blue, infrared, high first
// (R14) Host ends read with nack, stop
// (R15) Direction bit: 1 read, 0 write
// (R16) Pointer advances after every data byte
`default_nettype none
package csm_pkg;
  // ==========================================================
  // Link constants
  localparam logic [6:0] CSM_SLAVE_ADDR = 7'h2A;  // Sensor slave address
  localparam logic       CSM_DIR_READ   = 1'b1;   // Direction bit for reads
  localparam logic [3:0] CSM_BITS_BYTE  = 4'h8;   // Bits per byte

  // ==========================================================
  // Register offsets
  localparam logic [7:0] CSM_REG_CTRL   = 8'h00;  // measurement_control
  localparam logic [7:0] CSM_REG_MAN_HI = 8'h01;  // Manual timing high byte
  localparam logic [7:0] CSM_REG_MAN_LO = 8'h02;  // Manual timing low byte
  localparam logic [7:0] CSM_REG_RES0   = 8'h03;  // color_result_first_byte
  localparam logic [7:0] CSM_REG_RESN   = 8'h0A;  // Last result byte

  // ==========================================================
  // Control byte fields
  localparam int         CSM_CTRL_ADC_RST = 7;    // Converter held in reset
  localparam int         CSM_CTRL_STANDBY = 6;    // Sleep when set
  localparam int         CSM_CTRL_MANUAL  = 2;    // Manual timing select
  localparam int         CSM_CTRL_TINT_LO = 0;    // Step select, two bits
  localparam logic [7:0] CSM_CTRL_RESET   = 8'hC0;  // Reset and standby
  localparam logic [7:0] CSM_MAN_RESET    = 8'h00;  // Manual count reset

  // ==========================================================
  // Timing
  localparam int CSM_CLK_MHZ       = 100;         // System clock rate
  localparam int CSM_TINT00_US     = 100;         // Step unit, code 00
  localparam int CSM_TINT01_US     = 1000;        // Step unit, code 01
  localparam int CSM_TINT10_US     = 10000;       // Step unit, code 10
  localparam int CSM_TINT11_US     = 100000;      // Step unit, code 11
  localparam int CSM_TINT00_CYC    = CSM_TINT00_US * CSM_CLK_MHZ;
  localparam int CSM_TINT01_CYC    = CSM_TINT01_US * CSM_CLK_MHZ;
  localparam int CSM_TINT10_CYC    = CSM_TINT10_US * CSM_CLK_MHZ;
  localparam int CSM_TINT11_CYC    = CSM_TINT11_US * CSM_CLK_MHZ;
  localparam int CSM_NUM_CH        = 4;           // Red, green, blue, infrared
  localparam logic [15:0] CSM_SAT  = 16'hFFFF;    // Result saturation value

  // ==========================================================
  // Serial engine states
  typedef enum logic [6:0] {
    CSM_IDLE = 7'b000_0001,
    CSM_ADDR = 7'b000_0010,
    CSM_AACK = 7'b000_0100,
    CSM_WR   = 7'b000_1000,
    CSM_WACK = 7'b001_0000,
    CSM_RD   = 7'b010_0000,
    CSM_RACK = 7'b100_0000
  } csm_state_e;
endpackage
`default_nettype wire

// File: logic/csm_sync.sv
`default_nettype none
// ==========================================================
// Two-stage synchroniser for pin inputs
module csm_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         i_clk_sys,
  input  wire logic         i_srst,
  // Data
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync
);
  logic [W-1:0] meta;  // First stage, read only by second stage

  // Reset to ones: an idle open-drain bus sits high
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      meta   <= '1;
      o_sync <= '1;
    end else begin
      meta   <= i_async;
      o_sync <= meta;
    end
  end
endmodule
`default_nettype wire

// File: logic/csm_top.sv
`default_nettype none
// ==========================================================
// Colour sensor measurement core with serial register port
module csm_top
  import csm_pkg::*;
#(
  parameter int P_TINT00_CYC = CSM_TINT00_CYC,  // Step unit cycles, code 00
  parameter int P_TINT01_CYC = CSM_TINT01_CYC,  // Step unit cycles, code 01
  parameter int P_TINT10_CYC = CSM_TINT10_CYC,  // Step unit cycles, code 10
  parameter int P_TINT11_CYC = CSM_TINT11_CYC   // Step unit cycles, code 11
) (
  // Clock and reset
  input  wire logic       i_clk_sys,
  input  wire logic       i_srst,
  // Serial bus pins
  input  wire logic       i_scl,
  input  wire logic       i_sda,
  output logic            o_sda_out,
  output logic            o_sda_oe,
  // Light levels per unit step, same clock domain
  input  wire logic [7:0] i_lvl_red,
  input  wire logic [7:0] i_lvl_green,
  input  wire logic [7:0] i_lvl_blue,
  input  wire logic [7:0] i_lvl_ir,
  // Status
  output logic            o_meas_active,
  output logic            o_result_update
);
  // ==========================================================
  // Pin synchronisers and edge detection
  logic [1:0] pins_s;     // {scl, sda} after two flops
  logic       scl_q;      // Previous synced clock
  logic       sda_q;      // Previous synced data
  csm_sync #(.W(2)) u_sync (
    .i_clk_sys (i_clk_sys),
    .i_srst    (i_srst),
    .i_async   ({i_scl, i_sda}),
    .o_sync    (pins_s)
  );
  wire scl_s    = pins_s[1];
  wire sda_s    = pins_s[0];
  wire scl_rise = scl_s & ~scl_q;
  wire scl_fall = ~scl_s & scl_q;
  wire bus_strt = scl_s & scl_q & sda_q & ~sda_s;  // (R1)
  wire bus_stop = scl_s & scl_q & ~sda_q & sda_s;

  // History flops for edge detect
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl_s;
      sda_q <= sda_s;
    end
  end

  // ==========================================================
  // Register storage
  logic [7:0]  ctrl;                    // measurement_control
  logic [7:0]  man_hi;                  // Manual count, high
  logic [7:0]  man_lo;                  // Manual count, low
  logic [15:0] result [CSM_NUM_CH];     // Published results
  logic [15:0] acc    [CSM_NUM_CH];     // Channels of current cycle
  logic [7:0]  ptr;                     // Register pointer

  // Read data mux: results start at pointer 0x03, high byte first
  wire [7:0] res_off = ptr - CSM_REG_RES0;                            // (R9)
  wire       in_res  = (ptr >= CSM_REG_RES0) && (ptr <= CSM_REG_RESN);
  wire [1:0] res_ch  = res_off[2:1];                                  // (R13)
  wire [7:0] res_byte = res_off[0] ? result[res_ch][7:0]
                                   : result[res_ch][15:8];            // (R11)
  wire [7:0] rdata = in_res                  ? res_byte :
                     (ptr == CSM_REG_CTRL)   ? ctrl     :
                     (ptr == CSM_REG_MAN_HI) ? man_hi   :
                     (ptr == CSM_REG_MAN_LO) ? man_lo   : 8'h00;

  // ==========================================================
  // Serial engine
  csm_state_e st;
  logic [3:0] bitcnt;     // Bits seen in current byte
  logic [7:0] sh;         // Receive shift register
  logic [7:0] tx;         // Transmit shift register
  logic       rw;         // Direction of current transfer
  logic       first;      // Next written byte is the pointer
  logic       wr_stb;     // One-cycle write strobe
  logic [7:0] wr_dat;     // Byte to write at ptr
  logic [7:0] wr_adr;     // Register the strobe lands in
  wire  [7:0] sh_next = {sh[6:0], sda_s};
  wire        byte_end = scl_fall && (bitcnt == CSM_BITS_BYTE);
  wire        addr_hit = (sh[7:1] == CSM_SLAVE_ADDR);                 // (R1)

  // Start and stop override everything; bits move on clock edges
  always_ff @(posedge i_clk_sys) begin
    wr_stb <= 1'b0;
    if (i_srst) begin
      st       <= CSM_IDLE;
      bitcnt   <= 4'h0;
      sh       <= 8'h00;
      tx       <= 8'h00;
      rw       <= 1'b0;
      first    <= 1'b1;
      ptr      <= 8'h00;
      wr_dat   <= 8'h00;
      wr_adr   <= 8'h00;
      o_sda_oe <= 1'b0;
    end else if (bus_strt) begin
      // Repeated start re-addresses but keeps the pointer
      st       <= CSM_ADDR;
      bitcnt   <= 4'h0;
      first    <= 1'b1;
      o_sda_oe <= 1'b0;
    end else if (bus_stop) begin
      st       <= CSM_IDLE;
      o_sda_oe <= 1'b0;
    end else begin
      unique case (st)
        CSM_IDLE: begin
          o_sda_oe <= 1'b0;
        end
        CSM_ADDR, CSM_WR: begin
          if (scl_rise) begin
            sh     <= sh_next;
            bitcnt <= bitcnt + 4'h1;
          end else if (byte_end) begin
            bitcnt <= 4'h0;
            if (st == CSM_ADDR) begin
              // Foreign address: stay off the bus until next start
              st       <= addr_hit ? CSM_AACK : CSM_IDLE;         // (R1)
              o_sda_oe <= addr_hit;                               // (R12)
              rw       <= (sh[0] == CSM_DIR_READ);                // (R15)
            end else begin
              st       <= CSM_WACK;
              o_sda_oe <= 1'b1;                                   // (R12)
              first    <= 1'b0;
              if (first) begin
                ptr <= sh;                                        // (R2)
              end else begin
                // Latch the target before the pointer moves on
                wr_stb <= 1'b1;
                wr_dat <= sh;
                wr_adr <= ptr;                                    // (R16)
                ptr    <= ptr + 8'h01;                            // (R16)
              end
            end
          end
        end
        CSM_AACK: begin
          if (scl_fall) begin
            if (rw) begin
              st       <= CSM_RD;                                 // (R10)
              tx       <= rdata;
              o_sda_oe <= ~rdata[7];
            end else begin
              st       <= CSM_WR;
              o_sda_oe <= 1'b0;
            end
          end
        end
        CSM_WACK: begin
          if (scl_fall) begin
            st       <= CSM_WR;
            o_sda_oe <= 1'b0;
          end
        end
        CSM_RD: begin
          if (scl_rise) begin
            bitcnt <= bitcnt + 4'h1;
          end else if (byte_end) begin
            // Release the line so the host can acknowledge
            st       <= CSM_RACK;                                 // (R12)
            bitcnt   <= 4'h0;
            o_sda_oe <= 1'b0;
            ptr      <= ptr + 8'h01;                              // (R16)
          end else if (scl_fall) begin
            tx       <= {tx[6:0], 1'b0};
            o_sda_oe <= ~tx[6];
          end
        end
        CSM_RACK: begin
          if (scl_rise && sda_s) begin
            st <= CSM_IDLE;                                       // (R14)
          end else if (scl_fall) begin
            st       <= CSM_RD;                                   // (R13)
            tx       <= rdata;
            o_sda_oe <= ~rdata[7];
          end
        end
      endcase
    end
  end

  // Open-drain: only ever drive low
  always_ff @(posedge i_clk_sys) begin
    o_sda_out <= 1'b0;
  end

  // ==========================================================
  // Writable registers; results and unmapped bytes ignore writes
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      ctrl   <= CSM_CTRL_RESET;
      man_hi <= CSM_MAN_RESET;
      man_lo <= CSM_MAN_RESET;
    end else if (wr_stb) begin
      if (wr_adr == CSM_REG_CTRL) begin
        ctrl <= wr_dat;                                           // (R3) (R5)
      end
      if (wr_adr == CSM_REG_MAN_HI) begin
        man_hi <= wr_dat;                                         // (R4)
      end
      if (wr_adr == CSM_REG_MAN_LO) begin
        man_lo <= wr_dat;                                         // (R4)
      end
    end
  end

  // ==========================================================
  // Measurement sequencer
  wire        adc_hold = ctrl[CSM_CTRL_ADC_RST] | ctrl[CSM_CTRL_STANDBY];  // (R3)
  wire [1:0]  tint     = ctrl[CSM_CTRL_TINT_LO +: 2];
  wire [31:0] unit_cyc = (tint == 2'b00) ? 32'(P_TINT00_CYC) :
                         (tint == 2'b01) ? 32'(P_TINT01_CYC) :
                         (tint == 2'b10) ? 32'(P_TINT10_CYC) :
                                           32'(P_TINT11_CYC);
  // Fixed mode integrates one unit per channel; manual takes the count, or one unit when the count is zero
  wire [15:0] man_cnt  = {man_hi, man_lo};
  wire [15:0] steps    = (ctrl[CSM_CTRL_MANUAL] && (man_cnt != 16'h0000))
                         ? man_cnt : 16'h0001;                    // (R6)
  logic [31:0] unit_ctr;  // Cycles within one step
  logic [15:0] step_ctr;  // Steps within one channel
  logic [1:0]  ch;        // Channel being integrated
  wire  [7:0]  lvl = (ch == 2'd0) ? i_lvl_red   :
                     (ch == 2'd1) ? i_lvl_green :
                     (ch == 2'd2) ? i_lvl_blue  : i_lvl_ir;
  wire  [16:0] sum      = {1'b0, acc[ch]} + {9'h000, lvl};
  // Greater-or-equal so a timing change mid-channel cannot overrun a counter
  wire         unit_end = (unit_ctr >= unit_cyc - 32'h0000_0001);
  wire         ch_end   = unit_end && (step_ctr >= steps - 16'h0001);

  // Accumulate one level sample per unit step, saturating
  always_ff @(posedge i_clk_sys) begin
    o_result_update <= 1'b0;
    if (i_srst || adc_hold) begin
      unit_ctr <= 32'h0000_0000;
      step_ctr <= 16'h0000;
      ch       <= 2'd0;
      for (int i = 0; i < CSM_NUM_CH; i++) begin
        acc[i] <= 16'h0000;
      end
    end else begin
      unit_ctr <= unit_end ? 32'h0000_0000 : unit_ctr + 32'h0000_0001;
      if (unit_end) begin
        acc[ch]  <= sum[16] ? CSM_SAT : sum[15:0];                // (R6)
        step_ctr <= ch_end ? 16'h0000 : step_ctr + 16'h0001;
      end
      if (ch_end) begin
        ch <= ch + 2'd1;                                          // (R8)
        if (ch == 2'(CSM_NUM_CH - 1)) begin
          o_result_update <= 1'b1;
          for (int i = 0; i < CSM_NUM_CH; i++) begin
            acc[i] <= 16'h0000;
          end
        end
      end
    end
  end

  // Publish a full cycle at once so the result registers never mix cycles
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      for (int i = 0; i < CSM_NUM_CH; i++) begin
        result[i] <= 16'h0000;
      end
    end else if (!adc_hold && ch_end && ch == 2'(CSM_NUM_CH - 1)) begin
      for (int i = 0; i < CSM_NUM_CH - 1; i++) begin
        result[i] <= acc[i];                                      // (R8)
      end
      result[CSM_NUM_CH-1] <= sum[16] ? CSM_SAT : sum[15:0];
    end
  end

  // Activity flag
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      o_meas_active <= 1'b0;
    end else begin
      o_meas_active <= ~adc_hold;                                 // (R5)
    end
  end
endmodule
`default_nettype wire
